// >>> core/ocp_hiccup_pkg.sv
package overcurrent_hiccup_pkg;
  // sustained overcurrent window before hiccup
  localparam int unsigned OC_WINDOW_US    = 1500;
  // hiccup shutdown time
  localparam int unsigned HICCUP_MS       = 40;
  localparam int unsigned CLK_MHZ         = 125;
  // times convert to cycles by exact multiplication with CLK_MHZ, no rounding or minimum
  localparam int unsigned OC_WINDOW_CYC   = OC_WINDOW_US * CLK_MHZ;
  localparam int unsigned HICCUP_CYC      = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W           = 24;
  localparam logic [1:0]  SYNC_AGREE      = 2'b11;
  localparam logic [1:0]  SYNC_IDLE       = 2'b00;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_HICCUP = 2'b01,
    ST_SOFT   = 2'b10
  } hic_state_t;
endpackage : overcurrent_hiccup_pkg

// >>> core/ocp_hiccup_counter.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - An overcurrent flag ends the active gate pulse at once for the rest of that period.
// - Overcurrent counted in OC_WINDOW consecutive periods (OC_WINDOW_CYC periods by default) puts the block into hiccup.
// - Hiccup holds switching off about 40 ms and then requests a fresh soft start.
// - A clean period right after an overcurrent period still counts as overcurrent.
// - The duration counter clears after two consecutive clean periods, or at any boundary outside ST_RUN.
module overcurrent_hiccup_counter
  import overcurrent_hiccup_pkg::*;
#(
  parameter int unsigned OC_WINDOW = overcurrent_hiccup_pkg::OC_WINDOW_CYC,
  parameter int unsigned HICCUP_T  = overcurrent_hiccup_pkg::HICCUP_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic clk_en_i,
  input  wire logic oc_cmp_i,
  input  wire logic period_start_i,
  input  wire logic pwm_i,
  input  wire logic soft_done_i,
  output logic      gate_o,
  output logic      overcurrent_event_o,
  output logic      hiccup_o,
  output logic      soft_start_o
);
  import overcurrent_hiccup_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser: three stages, change taken when 2nd and 3rd agree
  logic [2:0]      sync_ff;
  logic            oc_ff;
  logic            term_ff;
  logic            seen_ff;
  logic            prev_ff;
  logic [CNT_W-1:0] dur_ff;
  logic [CNT_W-1:0] hic_ff;
  hic_state_t      st_ff;

  wire [1:0] agree_w    = sync_ff[2:1];
  wire       nxt_oc     = (agree_w == SYNC_AGREE) ? 1'b1 :
                          (agree_w == SYNC_IDLE)  ? 1'b0 : oc_ff;
  wire       period_oc  = seen_ff | oc_ff;
  // latched last result masks a single missed period
  wire       counted_oc = period_oc | prev_ff;
  wire       two_clean  = ~period_oc & ~prev_ff;
  wire       window_hit = (dur_ff == CNT_W'(OC_WINDOW - 1)) & counted_oc;
  wire       hic_done   = (hic_ff == CNT_W'(HICCUP_T - 1));
  wire       run_w      = (st_ff == ST_RUN);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_ff <= 3'h0;
      oc_ff   <= 1'b0;
    end else if (clk_en_i) begin
      sync_ff <= {sync_ff[1:0], oc_cmp_i};
      oc_ff   <= nxt_oc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle-by-cycle termination; stays off until next period boundary
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      term_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (period_start_i) begin
        term_ff <= 1'b0;
      end else if (oc_ff) begin
        term_ff <= 1'b1;
      end
    end
  end

  // combinational cut avoids the one-cycle delay of term_ff
  assign gate_o = pwm_i & run_w & ~oc_ff & ~term_ff & ~period_start_i;

  assign overcurrent_event_o = oc_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // per-period sticky flag and boundary counter
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_ff <= 1'b0;
      prev_ff <= 1'b0;
      dur_ff  <= '0;
    end else if (clk_en_i) begin
      if (period_start_i) begin
        seen_ff <= 1'b0;
        prev_ff <= period_oc;
        if (!run_w || two_clean) begin
          dur_ff <= '0;
        end else if (counted_oc && !window_hit) begin
          dur_ff <= dur_ff + CNT_W'(1);
        end
      end else if (oc_ff) begin
        seen_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hiccup sequencer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff  <= ST_RUN;
      hic_ff <= '0;
    end else if (clk_en_i) begin
      case (st_ff)
        ST_RUN: begin
          hic_ff <= '0;
          if (period_start_i && window_hit) begin
            st_ff <= ST_HICCUP;
          end
        end
        ST_HICCUP: begin
          hic_ff <= hic_ff + CNT_W'(1);
          if (hic_done) begin
            st_ff <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          hic_ff <= '0;
          if (soft_done_i) begin
            st_ff <= ST_RUN;
          end
        end
        default: begin
          st_ff  <= ST_RUN;
          hic_ff <= '0;
        end
      endcase
    end
  end

  assign hiccup_o     = (st_ff == ST_HICCUP);
  assign soft_start_o = (st_ff == ST_SOFT);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gate_cut;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      oc_ff |-> !gate_o;
  endproperty
  a_gate_cut: assert property (p_gate_cut) else $error("gate high during overcurrent");

  property p_stay_cut;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && oc_ff && !period_start_i) ##1 !period_start_i |-> !gate_o;
  endproperty
  a_stay_cut: assert property (p_stay_cut) else $error("gate resumed within period");

  property p_enter;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && run_w && period_start_i && window_hit) |=> hiccup_o;
  endproperty
  a_enter: assert property (p_enter) else $error("hiccup not entered");

  property p_hic_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      hiccup_o |-> !gate_o;
  endproperty
  a_hic_off: assert property (p_hic_off) else $error("switching during hiccup");

  property p_hic_end;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && hiccup_o && hic_done) |=> soft_start_o;
  endproperty
  a_hic_end: assert property (p_hic_end) else $error("no soft start after hiccup");

  property p_latch;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && run_w && period_start_i && prev_ff && !window_hit)
        |=> dur_ff == $past(dur_ff) + CNT_W'(1);
  endproperty
  a_latch: assert property (p_latch) else $error("latched period not counted");

  property p_clear;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && period_start_i && two_clean) |=> dur_ff == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && !period_start_i) |=> dur_ff == $past(dur_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved off boundary");

  // boundary at which the duration counter must step
  sequence s_counted_boundary;
    clk_en_i && run_w && period_start_i && counted_oc && !window_hit;
  endsequence

  // boundary that must leave the block running
  sequence s_quiet_boundary;
    clk_en_i && run_w && period_start_i && !window_hit;
  endsequence

  property p_count;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s_counted_boundary |=> dur_ff == $past(dur_ff) + CNT_W'(1);
  endproperty
  a_count: assert property (p_count) else $error("counted period not added");

  property p_no_early;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s_quiet_boundary |=> !hiccup_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("hiccup entered early");

  property p_prev;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && period_start_i) |=> prev_ff == $past(period_oc);
  endproperty
  a_prev: assert property (p_prev) else $error("period result not latched");

  property p_boundary_gate;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      period_start_i |-> !gate_o;
  endproperty
  a_boundary_gate: assert property (p_boundary_gate) else $error("gate high at boundary");

  property p_sync;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && agree_w == SYNC_AGREE) |=> oc_ff;
  endproperty
  a_sync: assert property (p_sync) else $error("agreed trip not taken");

  property p_soft_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (clk_en_i && soft_start_o && !soft_done_i) |=> soft_start_o;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft start dropped");

  // a frozen enable must not let the hiccup timer or the window creep
  property p_freeze;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !clk_en_i |=> $stable(st_ff) && $stable(dur_ff) && $stable(hic_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : overcurrent_hiccup_counter

// >>> bench/oc_sense_model.sv
`timescale 1ns/100ps
module oc_sense_model (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic oc_en_i,
  output logic      period_start_o,
  output logic      oc_cmp_o
);
  logic [2:0] ph_ff;
  // free-running 8-cycle switching period
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) ph_ff <= 3'h0;
    else ph_ff <= ph_ff + 3'h1;
  end
  assign period_start_o = rstn_i && (ph_ff == 3'h0);
  // trip early, release early so the 3-flop sync settles before the boundary
  assign oc_cmp_o = oc_en_i && (ph_ff >= 3'h1) && (ph_ff <= 3'h3);
endmodule : oc_sense_model

// >>> bench/ocp_hiccup_counter_tb_top.sv
`timescale 1ns/100ps
module overcurrent_hiccup_counter_tb_top;
  import overcurrent_hiccup_pkg::*;
  localparam int HIC_T = 20;
  logic sys_clk_i, rstn_i, oc_cmp_i, period_start_i, pwm_i, soft_done_i, oc_en, clk_en;
  logic gate_o, overcurrent_event_o, hiccup_o, soft_start_o, seen;
  int   n_fail, num_checks, cyc, k;
  oc_sense_model model_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .oc_en_i(oc_en),
    .period_start_o(period_start_i), .oc_cmp_o(oc_cmp_i));
  overcurrent_hiccup_counter #(.OC_WINDOW(4), .HICCUP_T(HIC_T)) dut_u (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .clk_en_i(clk_en), .oc_cmp_i(oc_cmp_i), .period_start_i(period_start_i),
    .pwm_i(pwm_i), .soft_done_i(soft_done_i), .gate_o(gate_o),
    .overcurrent_event_o(overcurrent_event_o), .hiccup_o(hiccup_o),
    .soft_start_o(soft_start_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task chk(input string nm, input logic s, input logic e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task nxt(input int n);
    repeat (n) @(posedge sys_clk_i iff period_start_i);
    #1;
  endtask : nxt
  // ceiling well above the ~240 cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task test_cut;
    oc_en = 1'b1;
    for (k = 0; k < 12 && overcurrent_event_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk("overcurrent_event_o", overcurrent_event_o, 1'b1);
    chk("gate_o at trip", gate_o, 1'b0);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("gate_o rest of period", gate_o, 1'b0);
    oc_en = 1'b0;
    nxt(1);
    chk("gate_o next period", gate_o, 1'b1);
    nxt(3);
    $display("test cut done");
  endtask : test_cut
  task test_noclr;
    seen = 1'b0;
    for (k = 0; k < 12; k++) begin
      oc_en = (k % 3 == 0);
      nxt(1);
      seen |= hiccup_o;
    end
    chk("hiccup_o two clean periods", seen, 1'b0);
    $display("test noclr done");
  endtask : test_noclr
  task test_hiccup;
    for (k = 0; k < 3; k++) begin
      oc_en = (k % 2 == 0);
      nxt(1);
    end
    chk("hiccup_o early", hiccup_o, 1'b0);
    oc_en = 1'b0;
    nxt(1);
    @(posedge sys_clk_i);
    #1;
    chk("hiccup_o alternating", hiccup_o, 1'b1);
    chk("gate_o in hiccup", gate_o, 1'b0);
    for (k = 0; k < 100 && hiccup_o; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    // entry cycle was seen before the loop started
    chk("hiccup length", k + 1 == HIC_T, 1'b1);
    chk("soft_start_o", soft_start_o, 1'b1);
    soft_done_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    soft_done_i = 1'b0;
    chk("soft_start_o done", soft_start_o, 1'b0);
    $display("test hiccup done");
  endtask : test_hiccup
  task test_freeze;
    clk_en = 1'b0;
    oc_en = 1'b1;
    nxt(3);
    chk("overcurrent_event_o frozen", overcurrent_event_o, 1'b0);
    chk("hiccup_o frozen", hiccup_o, 1'b0);
    clk_en = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk("overcurrent_event_o after freeze", overcurrent_event_o, 1'b1);
    chk("gate_o after freeze", gate_o, 1'b0);
    oc_en = 1'b0;
    nxt(3);
    chk("gate_o resumed", gate_o, 1'b1);
    $display("test freeze done");
  endtask : test_freeze
  initial begin
    rstn_i = 1'b0;
    pwm_i = 1'b1;
    soft_done_i = 1'b0;
    oc_en = 1'b0;
    clk_en = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    nxt(2);
    test_cut();
    test_noclr();
    test_hiccup();
    test_freeze();
    end_sim();
  end
endmodule : overcurrent_hiccup_counter_tb_top
